//--- verilog/osec_regs.vh
/*
 * Register offsets, field positions, reset values and counts for the
 * output sync and enable control block.
 * Assumes inclusion by bare name from the block's design file.
 */
`ifndef OSEC_REGS_VH
`define OSEC_REGS_VH

// Register offsets on the word-wide register port
`define OSEC_ADDR_GLOBAL 8'h00
`define OSEC_ADDR_CHPWR 8'h04
`define OSEC_ADDR_PLLPWR 8'h05
`define OSEC_ADDR_PUMP 8'h35
`define OSEC_ADDR_CH1 8'h39
`define OSEC_ADDR_CH2 8'h3f
`define OSEC_ADDR_CH3 8'h44
`define OSEC_ADDR_CH4 8'h49
`define OSEC_ADDR_STATUS 8'h50

// Reset values
`define OSEC_RST_GLOBAL 16'h0020
`define OSEC_RST_CHPWR 16'h0000
`define OSEC_RST_PLLPWR 16'h0000
`define OSEC_RST_PUMP 16'h0000
`define OSEC_RST_CH 16'h0008

// global_control fields
`define OSEC_G_PWR_OFF 1
`define OSEC_G_ALIGN 5
`define OSEC_G_SPREAD 8
`define OSEC_G_PIN_SEL 14

// channel_power_control: channel n off at bit (base + n - 1)
`define OSEC_P_CH_BASE 4
`define OSEC_P_CH4 7

// channel output control fields
`define OSEC_C_FORCE 0
`define OSEC_C_QLVL 1
`define OSEC_C_PART 3
`define OSEC_C_DLY_LO 4
`define OSEC_C_DLY_HI 8
`define OSEC_C_CLEAN 9

// Tri-level page pin codes
`define OSEC_PAGE_LOW 2'b00
`define OSEC_PAGE_MID 2'b01
`define OSEC_PAGE_HIGH 2'b11

// Fill count at which both compared synchroniser stages hold pin data
`define OSEC_SYNC_FULL 2'h3

// Output-clock periods that qualify an enable change
`define OSEC_OE_QUAL 3'h4

// Synchronised pin vector positions
`define OSEC_PIN_W 12
`define OSEC_PN_PDN 0
`define OSEC_PN_GOE 1
`define OSEC_PN_SPREAD 2
`define OSEC_PN_UP 3
`define OSEC_PN_DOWN 4
`define OSEC_PN_LOCK 5
`define OSEC_PN_OE_LO 6
`define OSEC_PN_OE_HI 9
`define OSEC_PN_PG_LO 10
`define OSEC_PN_PG_HI 11

`endif

//--- verilog/osec_top.v
/*
 * Output channel synchronisation and enable control: divider alignment
 * with per-channel first-edge delay, qualified output enables, mute
 * level, power-down decode, page-pin sampling, serial/GPIO choice,
 * spread control, frequency step pulses and lock status.
 * Assumes I_CLK is the PFD reference clock, an outside serial decoder
 * presents word writes and reads on the register port, and the channel
 * dividers and prescalers give one-cycle tick pulses on I_CLK.
 */
`timescale 1ns/10ps
`default_nettype none
`include "osec_regs.vh"

module osec_top (
    input wire I_CLK, // PFD reference clock, 100 MHz
    input wire I_SRST, // Synchronous reset, active high
    input wire [7:0] I_REG_ADDR, // Register offset
    input wire [15:0] I_REG_WDATA, // Register write data
    input wire I_REG_WR, // Write strobe, one cycle
    input wire I_REG_RD, // Read strobe, one cycle
    input wire I_PDN_PIN_N, // Power-down or divider_align_pin_n
    input wire I_GLOBAL_OE, // Global output enable pin
    input wire I_SPREAD_PIN, // Spread enable pin
    input wire I_STEP_UP, // step_up_input pin
    input wire I_STEP_DOWN, // step_down_input pin
    input wire I_PLL_LOCKED, // Lock detector level
    input wire [3:0] I_CH_OE, // channel_output_enable pins
    input wire [1:0] I_PAGE_LEVEL, // page_select_pin level code
    input wire [3:0] I_OUT_TICK, // Channel output clock period pulses
    input wire [3:0] I_PRE_TICK, // Channel prescaler period pulses
    output reg [15:0] O_REG_RDATA, // Read data
    output reg O_REG_RVALID, // Read data valid, one cycle
    output reg [3:0] O_DIV_RESET, // Channel divider held in reset
    output reg [3:0] O_DIV_RUN, // Channel divider clock gate open
    output reg [3:0] O_MUTE, // Channel output muted
    output reg [3:0] O_MUTE_LEVEL, // Level driven while muted
    output reg [3:0] O_CLEAN_UPDATE, // Glitchless divider update enable
    output reg O_BYPASS_ON, // Bypass output enabled
    output reg O_GLOBAL_PWR_OFF, // All supply domains off
    output reg [3:0] O_CH_PWR_OFF, // Channel power-off
    output reg [15:0] O_PLL_PWR, // pll_power_control contents
    output reg [15:0] O_PLL_PUMP, // pll_pump_counter_enable contents
    output reg O_SERIAL_EN, // Shared pins act as serial interface
    output reg O_PAGE, // Selected configuration page
    output reg O_SPREAD_ON, // Spread spectrum enabled
    output reg O_STEP_UP, // Numerator step up, one cycle
    output reg O_STEP_DOWN, // Numerator step down, one cycle
    output reg O_LOCK, // Lock status pin value
    output reg O_LOCK_OE // Lock status pin driven
);

    // Channel register offset by index
    function [7:0] ch_addr;
        input [1:0] idx;
        begin
            case (idx)
                2'd0: ch_addr = `OSEC_ADDR_CH1;
                2'd1: ch_addr = `OSEC_ADDR_CH2;
                2'd2: ch_addr = `OSEC_ADDR_CH3;
                default: ch_addr = `OSEC_ADDR_CH4;
            endcase
        end
    endfunction

    reg [15:0] glob_q;
    reg [15:0] chpwr_q;
    reg [15:0] pllpwr_q;
    reg [15:0] pump_q;
    reg [15:0] chreg_q [0:3];

    reg [`OSEC_PIN_W-1:0] s1_q;
    reg [`OSEC_PIN_W-1:0] s2_q;
    reg [`OSEC_PIN_W-1:0] s3_q;
    reg [`OSEC_PIN_W-1:0] pin_q;
    reg [`OSEC_PIN_W-1:0] pin_prev_q;

    reg [1:0] fill_q;
    reg page_done_q;
    reg serial_q;
    reg page_q;
    reg spread_pin_q;
    reg align_prev_q;

    reg [3:0] hold_q;
    reg [5:0] dly_q [0:3];
    reg [3:0] qual_q;
    reg [2:0] qcnt_q [0:3];

    wire pin_is_align;
    wire align_lvl;
    wire align_rise;
    wire glob_off;
    wire [3:0] ch_off;
    reg [3:0] req;
    reg [15:0] rd_d;
    integer i;
    integer j;

    // Pins: first stage feeds only the second; change taken when 2 and 3 agree
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            s1_q <= {`OSEC_PIN_W{1'b0}};
            s2_q <= {`OSEC_PIN_W{1'b0}};
            s3_q <= {`OSEC_PIN_W{1'b0}};
            pin_q <= {`OSEC_PIN_W{1'b0}};
            pin_prev_q <= {`OSEC_PIN_W{1'b0}};
            fill_q <= 2'h0;
        end else begin
            // Stage contents from reset are not pin data; count them out
            if (fill_q != `OSEC_SYNC_FULL) begin
                fill_q <= fill_q + 2'h1;
            end
            s1_q <= {I_PAGE_LEVEL, I_CH_OE, I_PLL_LOCKED, I_STEP_DOWN,
                     I_STEP_UP, I_SPREAD_PIN, I_GLOBAL_OE, I_PDN_PIN_N};
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < `OSEC_PIN_W; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    pin_q[i] <= s3_q[i];
                end
            end
            pin_prev_q <= pin_q;
        end
    end

    // Page pin caught once, after the synchroniser has filled
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            page_done_q <= 1'b0;
            serial_q <= 1'b1;
            page_q <= 1'b0;
        end else if (!page_done_q && fill_q == `OSEC_SYNC_FULL &&
                     s2_q[`OSEC_PN_PG_HI:`OSEC_PN_PG_LO] ==
                     s3_q[`OSEC_PN_PG_HI:`OSEC_PN_PG_LO]) begin
            page_done_q <= 1'b1;
            case (s3_q[`OSEC_PN_PG_HI:`OSEC_PN_PG_LO])
                `OSEC_PAGE_LOW: begin
                    serial_q <= 1'b0;
                    page_q <= 1'b0;
                end
                `OSEC_PAGE_HIGH: begin
                    serial_q <= 1'b0;
                    page_q <= 1'b1;
                end
                default: begin
                    serial_q <= 1'b1;
                    page_q <= 1'b0;
                end
            endcase
        end
    end

    // Registers; writes only land while the shared pins are serial
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            glob_q <= `OSEC_RST_GLOBAL;
            chpwr_q <= `OSEC_RST_CHPWR;
            pllpwr_q <= `OSEC_RST_PLLPWR;
            pump_q <= `OSEC_RST_PUMP;
            for (i = 0; i < 4; i = i + 1) begin
                chreg_q[i] <= `OSEC_RST_CH;
            end
        end else if (I_REG_WR && serial_q) begin
            if (I_REG_ADDR == `OSEC_ADDR_GLOBAL) begin
                glob_q <= I_REG_WDATA;
            end
            if (I_REG_ADDR == `OSEC_ADDR_CHPWR) begin
                chpwr_q <= I_REG_WDATA;
            end
            if (I_REG_ADDR == `OSEC_ADDR_PLLPWR) begin
                pllpwr_q <= I_REG_WDATA;
            end
            if (I_REG_ADDR == `OSEC_ADDR_PUMP) begin
                pump_q <= I_REG_WDATA;
            end
            for (i = 0; i < 4; i = i + 1) begin
                if (I_REG_ADDR == ch_addr(i[1:0])) begin
                    chreg_q[i] <= I_REG_WDATA;
                end
            end
        end
    end

    // Read mux; unmapped offsets read zero
    always @* begin
        rd_d = 16'h0000;
        case (I_REG_ADDR)
            `OSEC_ADDR_GLOBAL: rd_d = glob_q;
            `OSEC_ADDR_CHPWR: rd_d = chpwr_q;
            `OSEC_ADDR_PLLPWR: rd_d = pllpwr_q;
            `OSEC_ADDR_PUMP: rd_d = pump_q;
            `OSEC_ADDR_CH1: rd_d = chreg_q[0];
            `OSEC_ADDR_CH2: rd_d = chreg_q[1];
            `OSEC_ADDR_CH3: rd_d = chreg_q[2];
            `OSEC_ADDR_CH4: rd_d = chreg_q[3];
            `OSEC_ADDR_STATUS: rd_d = {4'h0, qual_q, hold_q, O_LOCK,
                                       O_SPREAD_ON, page_q, serial_q};
            default: rd_d = 16'h0000;
        endcase
    end

    always @(posedge I_CLK) begin
        if (I_SRST) begin
            O_REG_RDATA <= 16'h0000;
            O_REG_RVALID <= 1'b0;
        end else begin
            O_REG_RVALID <= I_REG_RD;
            if (I_REG_RD) begin
                O_REG_RDATA <= rd_d;
            end
        end
    end

    // Pin acts as align input or as active-low power-down
    assign pin_is_align = glob_q[`OSEC_G_PIN_SEL];
    assign align_lvl = glob_q[`OSEC_G_ALIGN] &
                       (pin_q[`OSEC_PN_PDN] | ~pin_is_align);
    assign align_rise = align_lvl & ~align_prev_q;
    assign glob_off = glob_q[`OSEC_G_PWR_OFF] |
                      (~pin_is_align & ~pin_q[`OSEC_PN_PDN]);
    assign ch_off = chpwr_q[`OSEC_P_CH_BASE+3:`OSEC_P_CH_BASE] |
                    {4{glob_off}};

    // Enable requests: pin enables only exist in pin mode
    always @* begin
        for (j = 0; j < 4; j = j + 1) begin
            req[j] = pin_q[`OSEC_PN_GOE] & ~ch_off[j] &
                     (serial_q | pin_q[`OSEC_PN_OE_LO + j]);
        end
    end

    // Alignment: hold while low, common release, then per-channel delay.
    // Channels with OSEC_C_PART set load in the same cycle, so equal delays line up.
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            align_prev_q <= 1'b1;
            hold_q <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                dly_q[i] <= 6'h00;
            end
        end else begin
            align_prev_q <= align_lvl;
            for (i = 0; i < 4; i = i + 1) begin
                if (!chreg_q[i][`OSEC_C_PART]) begin
                    hold_q[i] <= 1'b0;
                    dly_q[i] <= 6'h00;
                end else if (!align_lvl) begin
                    hold_q[i] <= 1'b1;
                    dly_q[i] <= 6'h00;
                end else if (align_rise) begin
                    // Field value n gives n+1 prescaler periods, so 31 -> 32
                    dly_q[i] <= {1'b0, chreg_q[i][`OSEC_C_DLY_HI:
                                 `OSEC_C_DLY_LO]} + 6'h01;
                end else if (dly_q[i] != 6'h00 && I_PRE_TICK[i]) begin
                    dly_q[i] <= dly_q[i] - 6'h01;
                    if (dly_q[i] == 6'h01) begin
                        hold_q[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // Enable qualification: a changed request must persist for four
    // output clock periods; a glitch shorter than that is dropped.
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            qual_q <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                qcnt_q[i] <= 3'h0;
            end
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                if (req[i] == qual_q[i]) begin
                    qcnt_q[i] <= 3'h0;
                end else if (I_OUT_TICK[i]) begin
                    if (qcnt_q[i] == `OSEC_OE_QUAL - 3'h1) begin
                        qual_q[i] <= req[i];
                        qcnt_q[i] <= 3'h0;
                    end else begin
                        qcnt_q[i] <= qcnt_q[i] + 3'h1;
                    end
                end
            end
        end
    end

    // Channel outputs
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            O_DIV_RESET <= 4'h0;
            O_DIV_RUN <= 4'h0;
            O_MUTE <= 4'hf;
            O_MUTE_LEVEL <= 4'h0;
            O_CLEAN_UPDATE <= 4'h0;
            O_CH_PWR_OFF <= 4'h0;
            O_GLOBAL_PWR_OFF <= 1'b0;
            O_BYPASS_ON <= 1'b0;
            O_PLL_PWR <= 16'h0000;
            O_PLL_PUMP <= 16'h0000;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                O_DIV_RESET[i] <= hold_q[i];
                // Gate sits at the divider, so an off divider cannot enable
                O_DIV_RUN[i] <= qual_q[i] & ~hold_q[i] & ~ch_off[i];
                O_MUTE[i] <= ~qual_q[i] | hold_q[i] | ch_off[i] |
                             chreg_q[i][`OSEC_C_FORCE];
                O_MUTE_LEVEL[i] <= chreg_q[i][`OSEC_C_QLVL];
                O_CLEAN_UPDATE[i] <= chreg_q[i][`OSEC_C_CLEAN];
            end
            O_CH_PWR_OFF <= ch_off;
            O_GLOBAL_PWR_OFF <= glob_off;
            // Bypass ignores the global enable
            O_BYPASS_ON <= ~chpwr_q[`OSEC_P_CH4] & ~glob_off;
            O_PLL_PWR <= pllpwr_q;
            O_PLL_PUMP <= pump_q;
        end
    end

    // Spread: the pin can only switch spread off, never back on
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            spread_pin_q <= 1'b1;
            O_SPREAD_ON <= 1'b0;
        end else begin
            if (!pin_q[`OSEC_PN_SPREAD] && page_done_q) begin
                spread_pin_q <= 1'b0;
            end
            O_SPREAD_ON <= glob_q[`OSEC_G_SPREAD] | spread_pin_q;
        end
    end

    // Step pulses, lock pin and mode outputs
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            O_STEP_UP <= 1'b0;
            O_STEP_DOWN <= 1'b0;
            O_LOCK <= 1'b0;
            O_LOCK_OE <= 1'b0;
            O_SERIAL_EN <= 1'b0;
            O_PAGE <= 1'b0;
        end else begin
            O_STEP_UP <= pin_q[`OSEC_PN_UP] &
                         ~pin_prev_q[`OSEC_PN_UP];
            O_STEP_DOWN <= pin_q[`OSEC_PN_DOWN] &
                           ~pin_prev_q[`OSEC_PN_DOWN];
            O_LOCK <= pin_q[`OSEC_PN_LOCK];
            O_LOCK_OE <= 1'b1;
            O_SERIAL_EN <= serial_q & page_done_q;
            O_PAGE <= page_q;
        end
    end

endmodule // osec_top
`default_nettype wire

//--- tb/osec_top_props.sv
/*
 * Concurrent checks on the ports of osec_top.
 * Assumes one clock, I_CLK, and the synchronous reset I_SRST.
 */
`timescale 1ns/10ps
`default_nettype none
module osec_props (
    input wire I_CLK, // Reference clock
    input wire I_SRST, // Synchronous reset
    input wire I_REG_RD, // Read strobe
    input wire I_SPREAD_PIN, // Spread pin
    input wire I_STEP_UP, // Step up pin
    input wire I_STEP_DOWN, // Step down pin
    input wire I_PLL_LOCKED, // Lock level
    input wire O_REG_RVALID, // Read data valid
    input wire [3:0] O_DIV_RESET, // Divider held
    input wire [3:0] O_DIV_RUN, // Divider gate open
    input wire [3:0] O_MUTE, // Output muted
    input wire O_BYPASS_ON, // Bypass enabled
    input wire O_GLOBAL_PWR_OFF, // All domains off
    input wire [3:0] O_CH_PWR_OFF, // Channel off
    input wire O_SPREAD_ON, // Spread on
    input wire O_STEP_UP, // Step up pulse
    input wire O_STEP_DOWN, // Step down pulse
    input wire O_LOCK // Lock status
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    chk_reset_mute: assert property (disable iff (1'b0)
        I_SRST |=> O_MUTE == 4'hf && O_DIV_RUN == 4'h0)
        else $error("outputs not muted after reset");
    chk_read_answer: assert property (I_REG_RD |=> O_REG_RVALID)
        else $error("read not answered next cycle");
    chk_hold_mutes: assert property (
        (O_DIV_RESET & $past(O_DIV_RESET) & ~O_MUTE) == 4'h0)
        else $error("held divider not muted");
    chk_hold_no_run: assert property (
        (O_DIV_RUN & $past(O_DIV_RESET) & O_DIV_RESET) == 4'h0)
        else $error("divider runs while held");
    chk_off_mutes: assert property (
        (O_CH_PWR_OFF & $past(O_CH_PWR_OFF) & ~O_MUTE) == 4'h0)
        else $error("powered-off channel not muted");
    chk_bypass_off: assert property (
        O_CH_PWR_OFF[3] && $past(O_CH_PWR_OFF[3]) |-> !O_BYPASS_ON)
        else $error("bypass on while channel four off");
    // Bypass is registered on the same edge as its power bits, so it never lags them
    chk_bypass_steady: assert property (
        !$past(I_SRST, 3) && ($stable(O_CH_PWR_OFF)
        && $stable(O_GLOBAL_PWR_OFF)) [*3] |-> $stable(O_BYPASS_ON))
        else $error("bypass moved without a power change");
    chk_step_up: assert property ($rose(I_STEP_UP) |-> ##[2:6] O_STEP_UP)
        else $error("no step up pulse");
    chk_step_dn: assert property ($rose(I_STEP_DOWN) |-> ##[2:6] O_STEP_DOWN)
        else $error("no step down pulse");
    chk_step_pulse: assert property (O_STEP_UP || O_STEP_DOWN |=>
        !O_STEP_UP && !O_STEP_DOWN)
        else $error("step pulse longer than one cycle");
    chk_lock_rise: assert property ($rose(I_PLL_LOCKED) |-> ##[2:6] O_LOCK)
        else $error("lock status not raised");
    chk_lock_fall: assert property ($fell(I_PLL_LOCKED) |-> ##[2:6] !O_LOCK)
        else $error("lock status not cleared");
    chk_spread_drop: assert property ($fell(O_SPREAD_ON) |-> !I_SPREAD_PIN)
        else $error("spread dropped while pin high");
endmodule // osec_props
bind osec_top osec_props osec_props_inst (.I_CLK(I_CLK), .I_SRST(I_SRST),
    .I_REG_RD(I_REG_RD), .I_SPREAD_PIN(I_SPREAD_PIN), .I_STEP_UP(I_STEP_UP),
    .I_STEP_DOWN(I_STEP_DOWN), .I_PLL_LOCKED(I_PLL_LOCKED),
    .O_REG_RVALID(O_REG_RVALID), .O_DIV_RESET(O_DIV_RESET),
    .O_DIV_RUN(O_DIV_RUN), .O_MUTE(O_MUTE), .O_BYPASS_ON(O_BYPASS_ON),
    .O_GLOBAL_PWR_OFF(O_GLOBAL_PWR_OFF), .O_CH_PWR_OFF(O_CH_PWR_OFF),
    .O_SPREAD_ON(O_SPREAD_ON), .O_STEP_UP(O_STEP_UP),
    .O_STEP_DOWN(O_STEP_DOWN), .O_LOCK(O_LOCK));
`default_nettype wire

//--- tb/osec_host.sv
/*
 * Host-side model holding the page, spread and power-down/align pins.
 * Assumes the bench requests level changes through its inputs.
 */
`timescale 1ns/10ps
`default_nettype none
module osec_host (
    input wire i_clk, // Reference clock
    input wire i_srst, // Synchronous reset
    input wire [1:0] i_page, // Requested page level code
    input wire i_drop_spread, // Request spread off
    input wire i_align_low, // Request align pin low
    output reg [1:0] o_page_level = 2'b01, // page_select_pin
    output reg o_spread_pin = 1'b1, // Spread pin
    output reg o_pdn_n = 1'b1 // Power-down or align pin
);
    always @(posedge i_clk) begin
        o_page_level <= i_page;
        o_pdn_n <= ~i_align_low;
        if (i_srst)
            o_spread_pin <= 1'b1;
        else if (i_drop_spread)
            o_spread_pin <= 1'b0;
    end
endmodule // osec_host
`default_nettype wire

//--- tb/osec_top_bench.sv
/*
 * Self-checking bench for osec_top: registers, alignment delay, enables,
 * spread, steps, lock and page pin.
 * Assumes osec_host holds the host pins and the bench makes the ticks.
 */
`timescale 1ns/10ps
`default_nettype none
`include "osec_regs.vh"
module osec_top_bench;
    reg clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, goe = 1'b1;
    reg up = 1'b0, dn = 1'b0, lock_in = 1'b0, drop = 1'b0, alow = 1'b0;
    reg [7:0] addr = 8'h00, cu, cd;
    reg [15:0] wdata = 16'h0000;
    reg [3:0] ch_oe = 4'hf, otick = 4'h0, ptick = 4'h0;
    reg [1:0] page = 2'b01;
    reg [15:0] r [0:3];
    integer n_fail = 0, tests_run = 0, seed = 29, i, k, c, d;
    integer fall [0:3];
    wire pdn_n, spread_pin, rvalid, byp, gpo, ser, pg, spr, sup, sdn, lk;
    wire lk_oe;
    wire [1:0] page_lvl;
    wire [15:0] rdata, pll_pwr, pump;
    wire [3:0] dreset, drun, mute, mlvl, clean, choff;
    always #5 clk = ~clk;
    osec_host osec_host_inst (.i_clk(clk), .i_srst(srst), .i_page(page),
        .i_drop_spread(drop), .i_align_low(alow), .o_page_level(page_lvl),
        .o_spread_pin(spread_pin), .o_pdn_n(pdn_n));
    osec_top osec_top_inst (.I_CLK(clk), .I_SRST(srst), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd),
        .I_PDN_PIN_N(pdn_n), .I_GLOBAL_OE(goe), .I_SPREAD_PIN(spread_pin),
        .I_STEP_UP(up), .I_STEP_DOWN(dn), .I_PLL_LOCKED(lock_in),
        .I_CH_OE(ch_oe), .I_PAGE_LEVEL(page_lvl), .I_OUT_TICK(otick),
        .I_PRE_TICK(ptick), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
        .O_DIV_RESET(dreset), .O_DIV_RUN(drun), .O_MUTE(mute),
        .O_MUTE_LEVEL(mlvl), .O_CLEAN_UPDATE(clean), .O_BYPASS_ON(byp),
        .O_GLOBAL_PWR_OFF(gpo), .O_CH_PWR_OFF(choff), .O_PLL_PWR(pll_pwr),
        .O_PLL_PUMP(pump), .O_SERIAL_EN(ser), .O_PAGE(pg),
        .O_SPREAD_ON(spr), .O_STEP_UP(sup), .O_STEP_DOWN(sdn), .O_LOCK(lk),
        .O_LOCK_OE(lk_oe));
    function [7:0] ch_addr(input integer n);
        ch_addr = (n == 0) ? `OSEC_ADDR_CH1 : (n == 1) ? `OSEC_ADDR_CH2 :
            (n == 2) ? `OSEC_ADDR_CH3 : `OSEC_ADDR_CH4;
    endfunction
    task report_and_stop;
        begin
            $display("Checks %0d, mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task check(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task check4(input string nm, input [3:0] s, input [3:0] e);
        check(nm, {12'h000, s}, {12'h000, e});
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task wr_reg(input [7:0] a, input [15:0] v);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= v;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    // Outputs read right after an edge hold what the previous edge left
    task rd_chk(input [7:0] a, input [15:0] exp);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            @(posedge clk);
            check4("rvalid", {3'b000, rvalid}, 4'h1);
            check("rdata", rdata, exp);
        end
    endtask
    // Ticks spaced four cycles so outputs launched by a tick have settled
    task pulse(input sel, input integer n);
        repeat (n) begin
            @(posedge clk);
            if (sel) ptick <= 4'hf;
            else otick <= 4'hf;
            @(posedge clk);
            ptick <= 4'h0;
            otick <= 4'h0;
            @(posedge clk);
            @(posedge clk);
        end
    endtask
    task do_reset;
        begin
            @(posedge clk);
            srst <= 1'b1;
            cyc(4);
            srst <= 1'b0;
            cyc(6);
        end
    endtask
    initial begin
        #1000000;
        n_fail = n_fail + 1;
        $display("MISMATCH run expected end seen hang");
        report_and_stop;
    end
    initial begin
        do_reset;
        rd_chk(`OSEC_ADDR_GLOBAL, `OSEC_RST_GLOBAL);
        rd_chk(`OSEC_ADDR_CHPWR, `OSEC_RST_CHPWR);
        rd_chk(`OSEC_ADDR_PLLPWR, `OSEC_RST_PLLPWR);
        rd_chk(`OSEC_ADDR_PUMP, `OSEC_RST_PUMP);
        for (i = 0; i < 4; i = i + 1)
            rd_chk(ch_addr(i), `OSEC_RST_CH);
        wr_reg(8'h10, 16'hffff);
        rd_chk(8'h10, 16'h0000);
        pulse(0, 4);
        check4("run", drun, 4'hf);
        check4("mute", mute, 4'h0);
        check4("pins", {ser, byp, spr, gpo}, 4'he);
        for (k = 0; k < 3; k = k + 1) begin
            for (i = 0; i < 4; i = i + 1) begin
                r[i] = $random(seed);
                r[i][3] = 1'b1;
                wr_reg(ch_addr(i), r[i]);
            end
            wr_reg(`OSEC_ADDR_PLLPWR, r[0] ^ 16'h5a5a);
            wr_reg(`OSEC_ADDR_PUMP, r[1]);
            cyc(3);
            for (i = 0; i < 4; i = i + 1)
                rd_chk(ch_addr(i), r[i]);
            check4("qlvl", mlvl, {r[3][1], r[2][1], r[1][1], r[0][1]});
            check4("clean", clean, {r[3][9], r[2][9], r[1][9], r[0][9]});
            check4("force", mute, {r[3][0], r[2][0], r[1][0], r[0][0]});
            check("pllpwr", pll_pwr, r[0] ^ 16'h5a5a);
            check("pump", pump, r[1]);
        end
        // Pass 0 aligns from the register bit, pass 1 from the pin
        for (k = 0; k < 2; k = k + 1) begin
            d = $random(seed) & 31;
            wr_reg(`OSEC_ADDR_CH1, {7'h00, d[4:0], 4'h8});
            wr_reg(`OSEC_ADDR_CH2, {7'h00, d[4:0], 4'h8});
            wr_reg(`OSEC_ADDR_CH3, 16'h01f8);
            wr_reg(`OSEC_ADDR_CH4, 16'h0000);
            wr_reg(`OSEC_ADDR_GLOBAL, (k == 0) ? 16'h0000 : 16'h4020);
            alow <= (k == 1);
            cyc(8);
            check4("held", dreset, 4'h7);
            check4("hmute", mute, 4'h7);
            if (k == 0) wr_reg(`OSEC_ADDR_GLOBAL, 16'h0020);
            else alow <= 1'b0;
            cyc(8);
            check4("wait", dreset, 4'h7);
            for (c = 0; c < 4; c = c + 1)
                fall[c] = 0;
            for (i = 1; i < 34; i = i + 1) begin
                pulse(1, 1);
                for (c = 0; c < 3; c = c + 1)
                    if (dreset[c] === 1'b0 && fall[c] == 0) fall[c] = i;
            end
            check("dly1", fall[0][15:0], d[15:0] + 16'h0001);
            check("dly2", fall[1][15:0], d[15:0] + 16'h0001);
            check("dly3", fall[2][15:0], 16'h0020);
            check4("free", mute, 4'h0);
        end
        wr_reg(`OSEC_ADDR_GLOBAL, 16'h0020);
        c = $random(seed) & 3;
        wr_reg(`OSEC_ADDR_CHPWR, 16'h0010 << c);
        cyc(3);
        check4("offm", mute, 4'h1 << c);
        check4("off", choff, 4'h1 << c);
        check4("byp", {3'b000, byp}, {3'b000, c != 3});
        pulse(0, 3);
        // Power-off shuts the gate at once; the enable itself lags 4 ticks
        check4("run3", drun, ~(4'h1 << c));
        rd_chk(`OSEC_ADDR_STATUS, 16'h0f05);
        pulse(0, 1);
        check4("run4", drun, ~(4'h1 << c));
        rd_chk(`OSEC_ADDR_STATUS, {4'h0, ~(4'h1 << c), 8'h05});
        wr_reg(`OSEC_ADDR_CHPWR, 16'h0000);
        cyc(2);
        pulse(0, 3);
        check4("on3", drun, ~(4'h1 << c));
        pulse(0, 1);
        check4("on4", drun, 4'hf);
        check4("onm", mute, 4'h0);
        goe <= 1'b0;
        cyc(6);
        pulse(0, 4);
        check4("goe", {drun[2:0], byp}, 4'h1);
        check4("goem", mute, 4'hf);
        goe <= 1'b1;
        cyc(6);
        pulse(0, 4);
        check4("goe1", drun, 4'hf);
        wr_reg(`OSEC_ADDR_GLOBAL, 16'h0122);
        drop <= 1'b1;
        cyc(8);
        check4("spr1", {2'b00, spr, gpo}, 4'h3);
        wr_reg(`OSEC_ADDR_GLOBAL, 16'h0020);
        cyc(3);
        check4("spr0", {3'b000, spr}, 4'h0);
        drop <= 1'b0;
        for (k = 0; k < 2; k = k + 1) begin
            cu = 0;
            cd = 0;
            if (k == 0) up <= 1'b1;
            else dn <= 1'b1;
            repeat (12) begin
                @(posedge clk);
                cu = cu + sup;
                cd = cd + sdn;
            end
            up <= 1'b0;
            dn <= 1'b0;
            check4("steps", {cd[1:0], cu[1:0]}, (k == 0) ? 4'h1 : 4'h4);
            cyc(6);
        end
        lock_in <= 1'b1;
        cyc(8);
        check4("lock", {2'b00, lk, lk_oe}, 4'h3);
        lock_in <= 1'b0;
        cyc(8);
        check4("unlock", {3'b000, lk}, 4'h0);
        for (k = 0; k < 2; k = k + 1) begin
            page <= (k == 0) ? `OSEC_PAGE_HIGH : `OSEC_PAGE_LOW;
            do_reset;
            check4("page", {2'b00, ser, pg}, (k == 0) ? 4'h1 : 4'h0);
            wr_reg(`OSEC_ADDR_CHPWR, 16'h00f0);
            rd_chk(`OSEC_ADDR_CHPWR, 16'h0000);
            ch_oe <= 4'he;
            cyc(6);
            pulse(0, 4);
            check4("pinoe", drun, 4'he);
            ch_oe <= 4'hf;
        end
        report_and_stop;
    end
endmodule // osec_top_bench
`default_nettype wire
